/* hdl/dsx_pkg.sv */
// Package of shared constants for the DSP core execution-control block.
package dsx_pkg;

	localparam logic [15:0] YMEM_LO_ADDR   = 16'h0900;
	localparam logic [15:0] YMEM_HI_ADDR   = 16'h09FF;
	localparam logic [15:0] PSV_BASE_ADDR  = 16'h8000;
	localparam logic [3:0]  MOD_STEP_FOUR  = 4'h4;

	localparam logic [11:0] REG_CORE_CTRL  = 12'h000;
	localparam logic [11:0] REG_STATUS     = 12'h004;
	localparam logic [11:0] REG_INT_CTRL   = 12'h008;
	localparam logic [11:0] REG_DO_COUNT   = 12'h00C;
	localparam logic [11:0] REG_EVT_STAT   = 12'h010;
	localparam logic [11:0] REG_EVT_MASK   = 12'h014;
	localparam logic [11:0] REG_DISI_CNT   = 12'h018;

	localparam int CC_PSV_BIT        = 2;
	localparam int CC_EARLY_EXIT_BIT = 11;
	localparam int STATUS_C_BIT      = 0;
	localparam int STATUS_SZ_BIT     = 1;
	localparam int STATUS_IPL_LSB    = 5;
	localparam int STATUS_ACC_LSB    = 10;
	localparam int IC_NST_BIT   = 15;

	localparam logic [15:0] CORE_CTRL_RST = 16'h0000;
	localparam logic [15:0] STATUS_RST    = 16'h0000;
	localparam logic [15:0] INT_CTRL_RST  = 16'h0000;
	localparam logic [2:0]  IPL_ALL_MASK  = 3'h7;
	localparam logic [2:0]  IPL_DISI_TOP  = 3'h6;
	localparam int          RETURN_CYCLES = 3;
	localparam logic [1:0]  RETURN_LAST   = 2'(RETURN_CYCLES - 1);

	localparam int EV_TRAP  = 0;
	localparam int EV_FWD   = 1;
	localparam int EV_EARLY_EXIT = 2;
	localparam int EV_IRQ   = 3;
	localparam int EV_WIDTH = 4;

	typedef enum logic [1:0] {
		DSX_OP_NONE  = 2'b00,
		DSX_OP_DAW   = 2'b01,
		DSX_OP_ARITH = 2'b10,
		DSX_OP_LOAD_ACC = 2'b11
	} dsx_flagop_type;

endpackage

/* hdl/dsx_sticky_bit.sv */
// Sticky event bit with set-over-clear: a set wins over a clear in the same cycle.
`timescale 1ns/1ns
`default_nettype none
module dsx_sticky_bit (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic set_evt,
	input  wire logic clr_req,
	output var  logic flag_q
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 1'b0;
		end else if (set_evt) begin
			flag_q <= 1'b1;
		end else if (clr_req) begin
			flag_q <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* hdl/dsx_exec_ctrl.sv */
// Execution-control logic of the DSP core: hazards, flags, loops and interrupts.
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module dsx_exec_ctrl #(
	parameter int DATA_W = 16
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              ywr_valid,
	input  wire logic [15:0]       ywr_addr,
	input  wire logic [DATA_W-1:0] ywr_data,
	input  wire logic              mac_valid,
	input  wire logic [15:0]       mac_addr,
	input  wire logic [3:0]        mac_step,
	input  wire logic              mac_wb,
	input  wire logic [DATA_W-1:0] mem_rdata,
	output logic      [DATA_W-1:0] mac_operand,
	output logic                   mac_fwd,
	output logic                   addr_trap,
	input  wire logic              src_valid,
	input  wire logic [15:0]       src_addr,
	output logic                   psv_fetch,
	input  wire dsx_pkg::dsx_flagop_type flag_op,
	input  wire logic              res_zero,
	input  wire logic              res_carry,
	input  wire logic [5:0]        res_acc_flags,
	input  wire logic              do_start,
	input  wire logic [15:0]       do_count_in,
	input  wire logic              do_end,
	output logic                   do_active,
	output logic                   do_branch,
	input  wire logic              disi_exec,
	input  wire logic [13:0]       disi_count,
	input  wire logic              return_exec,
	input  wire logic              irq_req,
	input  wire logic [2:0]        irq_level,
	output logic                   irq_take,
	output logic                   irq_out
);
	localparam logic [15:0] NESTED_ONE = 16'h0001;
	typedef struct packed {
		logic [15:0]                 core_ctrl;
		logic [15:0]                 status;
		logic [15:0]                 int_ctrl;
		logic [15:0]                 do_count;
		logic [15:0]                 do_saved;
		logic [15:0]                 do_depth;
		logic [dsx_pkg::EV_WIDTH-1:0] evt_mask;
		logic [13:0]                 disi_cnt;
		logic [1:0]                  ret_cyc;
		logic                        last_ywr;
		logic [15:0]                 last_yaddr;
		logic [DATA_W-1:0]           last_ydata;
		logic [DATA_W-1:0]           mac_operand;
		logic                        mac_fwd;
		logic                        addr_trap;
		logic                        psv_fetch;
		logic                        do_active;
		logic                        do_branch;
		logic                        irq_take;
		logic                        irq_out;
		logic [31:0]                 prdata;
		logic                        pready;
		logic                        pslverr;
	} dsx_state_type;
	dsx_state_type st_q;
	dsx_state_type st_d;
	logic [dsx_pkg::EV_WIDTH-1:0] evt_flag;
	logic [dsx_pkg::EV_WIDTH-1:0] evt_set;
	logic [dsx_pkg::EV_WIDTH-1:0] evt_clr;
	logic                         acc_wr;
	logic                         acc_rd;
	logic                         mac_in_y;
	logic                         psv_hit;
	logic                         irq_blocked;
	logic                         early_exit_req;

	////////////////////////////////////////////////////////////////////////////////////
	// Bus access decode and event flags.
	assign acc_wr = psel && penable && pwrite && !st_q.pready;
	assign acc_rd = psel && penable && !pwrite && !st_q.pready;
	assign mac_in_y = mac_addr >= dsx_pkg::YMEM_LO_ADDR && mac_addr <= dsx_pkg::YMEM_HI_ADDR;
	assign psv_hit = src_valid && src_addr > dsx_pkg::PSV_BASE_ADDR
		&& st_q.core_ctrl[dsx_pkg::CC_PSV_BIT];
	assign early_exit_req = acc_wr && paddr == dsx_pkg::REG_CORE_CTRL
		&& pwdata[dsx_pkg::CC_EARLY_EXIT_BIT];
	genvar gi;
	generate
		for (gi = 0; gi < dsx_pkg::EV_WIDTH; gi++) begin : g_evt
			assign evt_clr[gi] = acc_wr && paddr == dsx_pkg::REG_EVT_STAT && pwdata[gi];
			dsx_sticky_bit u_bit (
				.pclk    (pclk),
				.presetn (presetn),
				.set_evt (evt_set[gi]),
				.clr_req (evt_clr[gi]),
				.flag_q  (evt_flag[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////////
	// Interrupt gating by priority, temporary disable and return sequence.
	always_comb begin
		irq_blocked = 1'b0;
		if (st_q.status[dsx_pkg::STATUS_IPL_LSB +: 3] == dsx_pkg::IPL_ALL_MASK) begin
			irq_blocked = 1'b1;
		end else if (irq_level <= st_q.status[dsx_pkg::STATUS_IPL_LSB +: 3]) begin
			irq_blocked = 1'b1;
		end else if (st_q.disi_cnt != 14'h0000 && irq_level <= dsx_pkg::IPL_DISI_TOP) begin
			irq_blocked = 1'b1;
		end else if (st_q.int_ctrl[dsx_pkg::IC_NST_BIT] && st_q.ret_cyc == 2'h0
			&& st_q.irq_take) begin
			irq_blocked = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////
	// Next-state logic.
	always_comb begin
		st_d = st_q;
		evt_set = '0;
		st_d.pready = psel && penable && !st_q.pready;
		st_d.pslverr = 1'b0;
		st_d.do_branch = 1'b0;
		st_d.irq_take = 1'b0;
		st_d.addr_trap = 1'b0;
		st_d.psv_fetch = psv_hit;
		st_d.last_ywr = ywr_valid && ywr_addr >= dsx_pkg::YMEM_LO_ADDR
			&& ywr_addr <= dsx_pkg::YMEM_HI_ADDR;
		st_d.last_yaddr = ywr_addr;
		st_d.last_ydata = ywr_data;
		if (mac_valid) begin
			// A read right after a Y write to the same word takes the written data.
			if (st_q.last_ywr && mac_in_y && mac_addr == st_q.last_yaddr) begin
				st_d.mac_operand = st_q.last_ydata;
				st_d.mac_fwd = 1'b1;
				evt_set[dsx_pkg::EV_FWD] = 1'b1;
			end else begin
				st_d.mac_operand = mem_rdata;
				st_d.mac_fwd = 1'b0;
			end
			// Back-to-back plus-minus-four prefetches without write-back raise no trap.
			st_d.addr_trap = 1'b0;
		end
		// Status flag updates.
		case (flag_op)
			dsx_pkg::DSX_OP_DAW: begin
				st_d.status[dsx_pkg::STATUS_C_BIT] = st_q.status[dsx_pkg::STATUS_C_BIT]
					| res_carry;
			end
			dsx_pkg::DSX_OP_ARITH: begin
				st_d.status[dsx_pkg::STATUS_C_BIT] = res_carry;
				st_d.status[dsx_pkg::STATUS_SZ_BIT] = st_q.status[dsx_pkg::STATUS_SZ_BIT]
					& res_zero;
			end
			dsx_pkg::DSX_OP_LOAD_ACC: begin
				st_d.status[dsx_pkg::STATUS_ACC_LSB +: 6] = res_acc_flags;
			end
			default: begin
			end
		endcase
		// Hardware loop control with one saved outer count.
		if (do_start) begin
			st_d.do_saved = st_q.do_count;
			st_d.do_count = do_count_in;
			st_d.do_depth = st_q.do_depth + NESTED_ONE;
			st_d.do_active = 1'b1;
		end else if (early_exit_req && st_q.do_active) begin
			// Early exit ends the inner loop and restores the outer count.
			st_d.do_count = st_q.do_saved;
			st_d.do_depth = st_q.do_depth - NESTED_ONE;
			st_d.do_active = st_q.do_depth > NESTED_ONE;
			evt_set[dsx_pkg::EV_EARLY_EXIT] = 1'b1;
		end else if (do_end && st_q.do_active) begin
			if (st_q.do_count != 16'h0000) begin
				st_d.do_count = st_q.do_count - NESTED_ONE;
				st_d.do_branch = 1'b1;
			end else begin
				st_d.do_count = st_q.do_saved;
				st_d.do_depth = st_q.do_depth - NESTED_ONE;
				st_d.do_active = st_q.do_depth > NESTED_ONE;
			end
		end
		// Temporary interrupt disable counter, reloads even at zero.
		if (disi_exec) begin
			st_d.disi_cnt = disi_count + 14'h0001;
		end else if (st_q.disi_cnt != 14'h0000) begin
			st_d.disi_cnt = st_q.disi_cnt - 14'h0001;
		end
		// Return sequence cycle count.
		if (return_exec) begin
			st_d.ret_cyc = 2'h1;
		end else if (st_q.ret_cyc != 2'h0 && st_q.ret_cyc != dsx_pkg::RETURN_LAST) begin
			st_d.ret_cyc = st_q.ret_cyc + 2'h1;
		end else begin
			st_d.ret_cyc = 2'h0;
		end
		if (irq_req && !irq_blocked) begin
			st_d.irq_take = 1'b1;
			evt_set[dsx_pkg::EV_IRQ] = 1'b1;
		end
		// Register writes.
		if (acc_wr) begin
			case (paddr)
				dsx_pkg::REG_CORE_CTRL: begin
					st_d.core_ctrl = pwdata[15:0] & ~(16'h0001 << dsx_pkg::CC_EARLY_EXIT_BIT);
				end
				dsx_pkg::REG_STATUS: st_d.status = pwdata[15:0];
				dsx_pkg::REG_INT_CTRL: st_d.int_ctrl = pwdata[15:0];
				dsx_pkg::REG_DO_COUNT: st_d.do_count = pwdata[15:0];
				dsx_pkg::REG_EVT_STAT: begin
				end
				dsx_pkg::REG_EVT_MASK: st_d.evt_mask = pwdata[dsx_pkg::EV_WIDTH-1:0];
				default: st_d.pslverr = 1'b1;
			endcase
		end
		st_d.prdata = 32'h0000_0000;
		if (acc_rd) begin
			case (paddr)
				dsx_pkg::REG_CORE_CTRL: st_d.prdata = {16'h0000, st_q.core_ctrl};
				dsx_pkg::REG_STATUS: st_d.prdata = {16'h0000, st_q.status};
				dsx_pkg::REG_INT_CTRL: st_d.prdata = {16'h0000, st_q.int_ctrl};
				dsx_pkg::REG_DO_COUNT: st_d.prdata = {16'h0000, st_q.do_count};
				dsx_pkg::REG_EVT_STAT: st_d.prdata = {28'h000_0000, evt_flag};
				dsx_pkg::REG_EVT_MASK: st_d.prdata = {28'h000_0000, st_q.evt_mask};
				dsx_pkg::REG_DISI_CNT: st_d.prdata = {18'h0_0000, st_q.disi_cnt};
				default: st_d.pslverr = 1'b1;
			endcase
		end
		if (!(psel && penable && !st_q.pready)) begin
			st_d.pslverr = 1'b0;
		end
		st_d.irq_out = |(evt_flag & st_q.evt_mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign prdata      = st_q.prdata;
	assign pready      = st_q.pready;
	assign pslverr     = st_q.pslverr;
	assign mac_operand = st_q.mac_operand;
	assign mac_fwd     = st_q.mac_fwd;
	assign addr_trap   = st_q.addr_trap;
	assign psv_fetch   = st_q.psv_fetch;
	assign do_active   = st_q.do_active;
	assign do_branch   = st_q.do_branch;
	assign irq_take    = st_q.irq_take;
	assign irq_out     = st_q.irq_out;

	////////////////////////////////////////////////////////////////////////////////////
	// Checks.
	sequence s_ywrite;
		ywr_valid && ywr_addr >= dsx_pkg::YMEM_LO_ADDR && ywr_addr <= dsx_pkg::YMEM_HI_ADDR;
	endsequence
	sequence s_mac_same;
		mac_valid && mac_in_y && mac_addr == $past(ywr_addr);
	endsequence
	y_forward_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_ywrite ##1 s_mac_same |=> mac_fwd && mac_operand == $past(ywr_data, 2))
		else $error("Y write not forwarded to following read.");
	no_trap_a: assert property (@(posedge pclk) disable iff (!presetn)
		mac_valid && mac_step == dsx_pkg::MOD_STEP_FOUR && !mac_wb |=> !addr_trap)
		else $error("Address trap raised on prefetch pair.");
	daw_carry_a: assert property (@(posedge pclk) disable iff (!presetn)
		flag_op == dsx_pkg::DSX_OP_DAW && status_c() && !acc_wr |=> status_c())
		else $error("Decimal adjust cleared carry.");
	psv_fetch_a: assert property (@(posedge pclk) disable iff (!presetn)
		src_valid && src_addr > dsx_pkg::PSV_BASE_ADDR && st_q.core_ctrl[dsx_pkg::CC_PSV_BIT]
		|=> psv_fetch)
		else $error("Program-space view fetch missed.");
	psv_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		src_valid && src_addr <= dsx_pkg::PSV_BASE_ADDR |=> !psv_fetch)
		else $error("Program-space view fetch at or below base.");
	early_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
		early_exit_req && st_q.do_active && !do_start
		|=> st_q.do_count == $past(st_q.do_saved))
		else $error("Early exit did not restore outer count.");
	outer_resume_a: assert property (@(posedge pclk) disable iff (!presetn)
		early_exit_req && st_q.do_active && !do_start && st_q.do_depth > NESTED_ONE
		|=> do_active)
		else $error("Early exit ended the outer loop.");
	fwd_event_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(mac_fwd) |-> evt_flag[dsx_pkg::EV_FWD])
		else $error("Forwarded read left no event.");
	arith_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
		flag_op == dsx_pkg::DSX_OP_ARITH && !acc_wr
		|=> st_q.status[dsx_pkg::STATUS_C_BIT] == $past(res_carry))
		else $error("Carry not taken from arithmetic result.");
	load_acc_a: assert property (@(posedge pclk) disable iff (!presetn)
		flag_op == dsx_pkg::DSX_OP_LOAD_ACC && !acc_wr
		|=> st_q.status[dsx_pkg::STATUS_ACC_LSB +: 6] == $past(res_acc_flags))
		else $error("Accumulator flags not loaded.");
	ipl_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_q.status[dsx_pkg::STATUS_IPL_LSB +: 3] == dsx_pkg::IPL_ALL_MASK |=> !irq_take)
		else $error("Interrupt taken at full priority mask.");
	disi_block_a: assert property (@(posedge pclk) disable iff (!presetn)
		disi_exec && disi_count == 14'h0001 ##1 (irq_level <= 3'h6)[*2] |=> !irq_take)
		else $error("Temporary disable window leaked.");
	sequence s_return_start;
		return_exec;
	endsequence
	sequence s_irq_open;
		irq_req && irq_level > st_q.status[dsx_pkg::STATUS_IPL_LSB +: 3]
			&& st_q.disi_cnt == 14'h0000 && !st_q.irq_take;
	endsequence
	ret_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_return_start ##1 s_irq_open |=> irq_take && !addr_trap)
		else $error("Interrupt during return not serviced.");
	irq_event_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(irq_take) |-> evt_flag[dsx_pkg::EV_IRQ])
		else $error("Taken interrupt left no event.");
	nest_block_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_q.int_ctrl[dsx_pkg::IC_NST_BIT] && st_q.irq_take && st_q.ret_cyc == 2'h0
		|=> !irq_take)
		else $error("Nested interrupt taken while nesting disabled.");

	function automatic logic status_c();
		return st_q.status[dsx_pkg::STATUS_C_BIT];
	endfunction
endmodule
`default_nettype wire

/* verif/dsx_exec_ctrl_tb.sv */
// Self-checking testbench of the DSP core execution-control block.
`timescale 1ns/1ns
`default_nettype none
module dsx_exec_ctrl_tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        ywr_valid, mac_valid, mac_wb, mac_fwd, addr_trap, src_valid, psv_fetch;
	logic [15:0] ywr_addr, ywr_data, mac_addr, mem_rdata, mac_operand, src_addr, do_count_in;
	logic [3:0]  mac_step;
	logic        res_zero, res_carry, do_start, do_end, do_active, do_branch;
	logic [5:0]  res_acc_flags;
	logic        disi_exec, return_exec, irq_req, irq_take, irq_out, err;
	logic [13:0] disi_count;
	logic [2:0]  irq_level;
	dsx_pkg::dsx_flagop_type flag_op;
	int          miscompares, check_count, cyc, n, nb;
	dsx_exec_ctrl i_dsx_exec_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ywr_valid(ywr_valid), .ywr_addr(ywr_addr),
		.ywr_data(ywr_data), .mac_valid(mac_valid), .mac_addr(mac_addr), .mac_step(mac_step),
		.mac_wb(mac_wb), .mem_rdata(mem_rdata), .mac_operand(mac_operand), .mac_fwd(mac_fwd),
		.addr_trap(addr_trap), .src_valid(src_valid), .src_addr(src_addr),
		.psv_fetch(psv_fetch), .flag_op(flag_op), .res_zero(res_zero), .res_carry(res_carry),
		.res_acc_flags(res_acc_flags), .do_start(do_start), .do_count_in(do_count_in),
		.do_end(do_end), .do_active(do_active), .do_branch(do_branch), .disi_exec(disi_exec),
		.disi_count(disi_count), .return_exec(return_exec), .irq_req(irq_req),
		.irq_level(irq_level), .irq_take(irq_take), .irq_out(irq_out));
	////////////////////////////////////////////////////////////////////////////////
	// Clock and timeout.
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			miscompares++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Shared tasks.
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1)
			miscompares++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic step();
		@(posedge pclk);
		#1;
	endtask
	task automatic test_done();
		$display("Checks made %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Scenarios.
	task automatic t_regs();
		apb(0, dsx_pkg::REG_STATUS, 0);
		chk("status reset", rd, {16'h0000, dsx_pkg::STATUS_RST});
		apb(0, dsx_pkg::REG_INT_CTRL, 0);
		chk("intctl reset", rd, {16'h0000, dsx_pkg::INT_CTRL_RST});
		apb(1, 12'h0FC, 32'h0000_FFFF);
		chk("unmapped err", {31'h0000_0000, err}, 32'h0000_0001);
		$display("test regs done");
	endtask
	task automatic t_ymem();
		@(posedge pclk);
		ywr_valid <= 1'b1;
		ywr_addr <= 16'h09FF;
		ywr_data <= 16'hA5C3;
		@(posedge pclk);
		ywr_valid <= 1'b0;
		mac_valid <= 1'b1;
		mac_addr <= 16'h09FF;
		mac_step <= dsx_pkg::MOD_STEP_FOUR;
		mem_rdata <= 16'h1111;
		step();
		chk("mac operand", {16'h0000, mac_operand}, 32'h0000_A5C3);
		chk("mac forward", {31'h0000_0000, mac_fwd}, 32'h0000_0001);
		chk("trap first", {31'h0000_0000, addr_trap}, 32'h0000_0000);
		mac_addr <= 16'h0900;
		step();
		chk("no forward", {16'h0000, mac_operand}, 32'h0000_1111);
		chk("trap second", {31'h0000_0000, addr_trap}, 32'h0000_0000);
		mac_valid <= 1'b0;
		$display("test ymem done");
	endtask
	task automatic t_flags();
		apb(1, dsx_pkg::REG_STATUS, 32'h0000_0001);
		flag_op <= dsx_pkg::DSX_OP_DAW;
		res_carry <= 1'b0;
		@(posedge pclk);
		flag_op <= dsx_pkg::DSX_OP_NONE;
		apb(0, dsx_pkg::REG_STATUS, 0);
		chk("daw carry", {31'h0000_0000, rd[0]}, 32'h0000_0001);
		apb(1, dsx_pkg::REG_CORE_CTRL, 32'h0000_0004);
		src_valid <= 1'b1;
		src_addr <= 16'h8001;
		flag_op <= dsx_pkg::DSX_OP_ARITH;
		res_carry <= 1'b0;
		step();
		chk("psv above", {31'h0000_0000, psv_fetch}, 32'h0000_0001);
		src_addr <= dsx_pkg::PSV_BASE_ADDR;
		flag_op <= dsx_pkg::DSX_OP_LOAD_ACC;
		res_acc_flags <= 6'h2D;
		step();
		chk("psv base", {31'h0000_0000, psv_fetch}, 32'h0000_0000);
		src_valid <= 1'b0;
		flag_op <= dsx_pkg::DSX_OP_NONE;
		apb(0, dsx_pkg::REG_STATUS, 0);
		chk("arith carry", {31'h0000_0000, rd[0]}, 32'h0000_0000);
		chk("lac flags", 32'(rd[15:10]), 32'h0000_002D);
		$display("test flags done");
	endtask
	task automatic t_loops();
		@(posedge pclk);
		do_start <= 1'b1;
		do_count_in <= 16'h0002;
		@(posedge pclk);
		@(posedge pclk);
		do_start <= 1'b0;
		apb(1, dsx_pkg::REG_CORE_CTRL, 32'h0000_0800);
		step();
		step();
		chk("outer alive", {31'h0000_0000, do_active}, 32'h0000_0001);
		nb = 0;
		for (n = 0; n < 8 && do_active === 1'b1; n++) begin
			do_end <= 1'b1;
			step();
			if (do_branch === 1'b1)
				nb++;
		end
		do_end <= 1'b0;
		chk("outer ends", {31'h0000_0000, do_active}, 32'h0000_0000);
		chk("outer branches", nb, 32'h0000_0002);
		$display("test loops done");
	endtask
	task automatic t_irq();
		apb(1, dsx_pkg::REG_STATUS, 32'h0000_00E0);
		irq_req <= 1'b1;
		irq_level <= 3'h7;
		for (n = 0; n < 4; n++) begin
			step();
			chk("ipl7 blocks", {31'h0000_0000, irq_take}, 32'h0000_0000);
		end
		irq_req <= 1'b0;
		apb(1, dsx_pkg::REG_STATUS, 32'h0000_0000);
		disi_exec <= 1'b1;
		disi_count <= 14'h0001;
		step();
		disi_exec <= 1'b0;
		irq_req <= 1'b1;
		irq_level <= 3'h6;
		step();
		chk("disi blocks", {31'h0000_0000, irq_take}, 32'h0000_0000);
		for (n = 0; n < 6 && irq_take !== 1'b1; n++)
			step();
		irq_req <= 1'b0;
		chk("irq taken", {31'h0000_0000, irq_take}, 32'h0000_0001);
		repeat (3) step();
		chk("masked out", {31'h0000_0000, irq_out}, 32'h0000_0000);
		apb(0, dsx_pkg::REG_EVT_STAT, 0);
		chk("event taken", {31'h0000_0000, rd[dsx_pkg::EV_IRQ]}, 32'h0000_0001);
		apb(1, dsx_pkg::REG_EVT_MASK, 32'h0000_0008);
		repeat (2) step();
		chk("irq out", {31'h0000_0000, irq_out}, 32'h0000_0001);
		apb(1, dsx_pkg::REG_EVT_STAT, 32'h0000_000F);
		repeat (2) step();
		chk("irq cleared", {31'h0000_0000, irq_out}, 32'h0000_0000);
		return_exec <= 1'b1;
		step();
		return_exec <= 1'b0;
		irq_req <= 1'b1;
		irq_level <= 3'h5;
		step();
		chk("irq in return", {31'h0000_0000, irq_take}, 32'h0000_0001);
		irq_req <= 1'b0;
		apb(1, dsx_pkg::REG_INT_CTRL, 32'h0000_8000);
		irq_req <= 1'b1;
		step();
		chk("first taken", {31'h0000_0000, irq_take}, 32'h0000_0001);
		step();
		chk("nest blocked", {31'h0000_0000, irq_take}, 32'h0000_0000);
		irq_req <= 1'b0;
		$display("test irq done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, ywr_valid, ywr_addr, ywr_data} = '0;
		{mac_valid, mac_addr, mac_step, mac_wb, mem_rdata, src_valid, src_addr} = '0;
		{res_zero, res_carry, res_acc_flags, do_start, do_count_in, do_end} = '0;
		{disi_exec, disi_count, return_exec, irq_req, irq_level} = '0;
		flag_op = dsx_pkg::DSX_OP_NONE;
		miscompares = 0;
		check_count = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_ymem();
		t_flags();
		t_loops();
		t_irq();
		test_done();
	end
endmodule
`default_nettype wire
